// ==== logic/flash_host_pkg.sv ====
// constants, types and state record of the flash command controller
// How it works
// - after reset-read from program or erase, wait the recovery interval first; the code waits only while mode_busy is still set by a block erase
// - append erase blocks only while the erase window flag still reads 0
// - detect chip erase completion by polling the toggle flag, not the ready output
// - confirm completion by the polling flags before trusting the fail flag
// - reset-read is one F0h write to 5555h, always after the two unlock cycles
// - unlock writes AAh to 5555h, then 55h to 2AAAh
`default_nettype none
package flash_host_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 20;
  localparam int WE_LOW_NS    = 50;
  localparam int ACCESS_NS    = 100;
  localparam int RECOV_US     = 10;
  localparam int SYNC_STAGES  = 2;
  localparam logic [9:0] WR_LOW_CYC  = 10'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] RD_WAIT_CYC = 10'((ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  localparam logic [9:0] RECOV_CYC   = 10'((RECOV_US * 1000 + CLK_NS - 1) / CLK_NS);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RDATA  = 8'h10;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_READY = 4;
  localparam int ST_MODE = 5;

  // ----------------------------------------------------------------
  // operations and flash bus values
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_READ    = 4'h0;
  localparam logic [3:0] OP_RESET   = 4'h1;
  localparam logic [3:0] OP_SIG     = 4'h2;
  localparam logic [3:0] OP_PROGRAM = 4'h3;
  localparam logic [3:0] OP_BLK_ERA = 4'h4;
  localparam logic [3:0] OP_ADD_BLK = 4'h5;
  localparam logic [3:0] OP_CHIP    = 4'h6;
  localparam logic [3:0] OP_SUSPEND = 4'h7;
  localparam logic [3:0] OP_RESUME  = 4'h8;
  localparam logic [3:0] OP_POLL    = 4'h9;
  localparam logic [18:0] UNLOCK_A1 = 19'h05555;
  localparam logic [18:0] UNLOCK_A2 = 19'h02AAA;
  localparam logic [7:0]  UNLOCK_D1 = 8'hAA;
  localparam logic [7:0]  UNLOCK_D2 = 8'h55;
  localparam logic [7:0]  CMD_RESET = 8'hF0;
  localparam logic [7:0]  CMD_SIG   = 8'h90;
  localparam logic [7:0]  CMD_PROG  = 8'hA0;
  localparam logic [7:0]  CMD_ERASE = 8'h80;
  localparam logic [7:0]  CMD_CHIP  = 8'h10;
  localparam logic [7:0]  CMD_BLOCK = 8'h30;
  localparam logic [7:0]  CMD_PAUSE = 8'hB0;
  localparam int BIT_POLL = 7;
  localparam int BIT_TOGGLE = 6;
  localparam int BIT_FAIL = 5;
  localparam int BIT_WINDOW = 3;

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_WR, S_GAP, S_RD, S_RGAP, S_RECOV} seq_state_t;

  typedef struct packed {
    seq_state_t  st;
    logic [3:0]  op;
    logic [2:0]  step;
    logic [9:0]  cnt;
    logic [18:0] cfg_addr;
    logic [7:0]  cfg_data;
    logic [18:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  prev;
    logic        second;
    logic        mode_busy;
    logic        done;
    logic        fail;
    logic        refused;
    logic [18:0] pin_addr;
    logic [7:0]  pin_dq;
    logic        pin_dq_oe;
    logic        pin_ce_n;
    logic        pin_oe_n;
    logic        pin_we_n;
    logic [7:0]  dq_s1;
    logic [7:0]  dq_s2;
    logic        rb_s1;
    logic        rb_s2;
  } ctl_state_t;

  localparam ctl_state_t CTL_RESET = '{st: S_IDLE, pin_ce_n: 1'b1, pin_oe_n: 1'b1,
                                       pin_we_n: 1'b1, default: '0};
endpackage : flash_host_pkg
`default_nettype wire

// ==== logic/flash_host_ctl.sv ====
// APB-controlled command sequencer that drives a byte-wide flash over its pins
`default_nettype none
module flash_host_ctl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [18:0] flash_addr,
  output logic      [7:0]  dq_out,
  output logic             dq_oe,
  input  wire logic [7:0]  dq_in,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  input  wire logic        ready_busy_out
);
  flash_host_pkg::ctl_state_t s_reg;
  flash_host_pkg::ctl_state_t s_next;

  // ----------------------------------------------------------------
  // command sequence tables
  // ----------------------------------------------------------------
  function automatic logic [2:0] write_count(input logic [3:0] op);
    unique case (op)
      flash_host_pkg::OP_RESET, flash_host_pkg::OP_SIG: write_count = 3'd3;
      flash_host_pkg::OP_PROGRAM:                        write_count = 3'd4;
      flash_host_pkg::OP_BLK_ERA, flash_host_pkg::OP_CHIP: write_count = 3'd6;
      flash_host_pkg::OP_ADD_BLK, flash_host_pkg::OP_SUSPEND,
      flash_host_pkg::OP_RESUME:                         write_count = 3'd1;
      default:                                           write_count = 3'd0;
    endcase
  endfunction : write_count

  function automatic logic [7:0] first_cmd(input logic [3:0] op);
    unique case (op)
      flash_host_pkg::OP_RESET:   first_cmd = flash_host_pkg::CMD_RESET;
      flash_host_pkg::OP_SIG:     first_cmd = flash_host_pkg::CMD_SIG;
      flash_host_pkg::OP_PROGRAM: first_cmd = flash_host_pkg::CMD_PROG;
      flash_host_pkg::OP_SUSPEND: first_cmd = flash_host_pkg::CMD_PAUSE;
      flash_host_pkg::OP_BLK_ERA, flash_host_pkg::OP_CHIP: first_cmd = flash_host_pkg::CMD_ERASE;
      default:                    first_cmd = flash_host_pkg::CMD_BLOCK;
    endcase
  endfunction : first_cmd

  // returns {address, data} of one write cycle
  function automatic logic [26:0] write_word(input logic [3:0] op, input logic [2:0] step,
                                             input logic [18:0] a, input logic [7:0] d);
    logic single;
    single = (write_count(op) == 3'd1);
    write_word = {flash_host_pkg::UNLOCK_A1, first_cmd(op)};
    if (single)
      write_word = {(op == flash_host_pkg::OP_ADD_BLK) ? a : 19'h00000, first_cmd(op)};
    else if (step == 3'd0 || step == 3'd3)
      write_word = {flash_host_pkg::UNLOCK_A1, flash_host_pkg::UNLOCK_D1};
    else if (step == 3'd1 || step == 3'd4)
      write_word = {flash_host_pkg::UNLOCK_A2, flash_host_pkg::UNLOCK_D2};
    else if (step == 3'd3 && op == flash_host_pkg::OP_PROGRAM)
      write_word = {a, d};
    else if (step == 3'd5)
      write_word = (op == flash_host_pkg::OP_CHIP)
                   ? {flash_host_pkg::UNLOCK_A1, flash_host_pkg::CMD_CHIP}
                   : {a, flash_host_pkg::CMD_BLOCK};
    if (op == flash_host_pkg::OP_PROGRAM && step == 3'd3)
      write_word = {a, d};
  endfunction : write_word

  function automatic logic is_poll_op(input logic [3:0] op);
    is_poll_op = (op == flash_host_pkg::OP_PROGRAM) || (op == flash_host_pkg::OP_CHIP) ||
                 (op == flash_host_pkg::OP_POLL) || (op == flash_host_pkg::OP_SUSPEND);
  endfunction : is_poll_op

  // ----------------------------------------------------------------
  // sequencer and register file
  // ----------------------------------------------------------------
  logic        apb_wr;
  logic        go_wr;
  logic        go_rd;
  logic        finish;
  logic [2:0]  wr_step;
  logic [26:0] wword;

  always_comb
  begin
    s_next = s_reg;
    go_wr = 1'b0;
    go_rd = 1'b0;
    finish = 1'b0;
    wr_step = 3'd0;
    s_next.dq_s1 = dq_in;
    s_next.dq_s2 = s_reg.dq_s1;
    s_next.rb_s1 = ready_busy_out;
    s_next.rb_s2 = s_reg.rb_s1;
    apb_wr = psel && penable && pwrite;
    if (apb_wr && paddr == flash_host_pkg::OFS_ADDR)
      s_next.cfg_addr = pwdata[18:0];
    if (apb_wr && paddr == flash_host_pkg::OFS_WDATA)
      s_next.cfg_data = pwdata[7:0];
    unique case (s_reg.st)
      flash_host_pkg::S_IDLE:
      begin
        if (apb_wr && paddr == flash_host_pkg::OFS_CTRL)
        begin
          s_next.op = pwdata[3:0];
          s_next.addr = s_reg.cfg_addr;
          s_next.wdata = s_reg.cfg_data;
          s_next.done = 1'b0;
          s_next.fail = 1'b0;
          s_next.refused = 1'b0;
          s_next.second = 1'b0;
          // block append looks at the window flag before writing
          if (pwdata[3:0] == flash_host_pkg::OP_ADD_BLK || write_count(pwdata[3:0]) == 3'd0)
            go_rd = 1'b1;
          else
            go_wr = 1'b1;
        end
      end
      flash_host_pkg::S_WR:
      begin
        s_next.cnt = s_reg.cnt - 10'd1;
        if (s_reg.cnt == 10'd0)
        begin
          s_next.pin_we_n = 1'b1;
          s_next.pin_ce_n = 1'b1;
          s_next.st = flash_host_pkg::S_GAP;
        end
      end
      flash_host_pkg::S_GAP:
      begin
        s_next.pin_dq_oe = 1'b0;
        if (s_reg.step + 3'd1 < write_count(s_reg.op))
        begin
          go_wr = 1'b1;
          wr_step = s_reg.step + 3'd1;
        end
        else
        begin
          unique case (s_reg.op)
            flash_host_pkg::OP_RESET:
            begin
              s_next.mode_busy = 1'b0;
              if (s_reg.mode_busy)
              begin
                s_next.st = flash_host_pkg::S_RECOV;
                s_next.cnt = flash_host_pkg::RECOV_CYC - 10'd1;
              end
              else
                finish = 1'b1;
            end
            flash_host_pkg::OP_PROGRAM, flash_host_pkg::OP_CHIP:
            begin
              s_next.mode_busy = 1'b1;
              go_rd = 1'b1;
            end
            flash_host_pkg::OP_BLK_ERA, flash_host_pkg::OP_ADD_BLK:
            begin
              s_next.mode_busy = 1'b1;
              finish = 1'b1;
            end
            flash_host_pkg::OP_SIG, flash_host_pkg::OP_SUSPEND: go_rd = 1'b1;
            default: finish = 1'b1;
          endcase
        end
      end
      flash_host_pkg::S_RD:
      begin
        s_next.cnt = s_reg.cnt - 10'd1;
        if (s_reg.cnt == 10'd0)
        begin
          s_next.rdata = s_reg.dq_s2;
          s_next.pin_ce_n = 1'b1;
          s_next.pin_oe_n = 1'b1;
          s_next.st = flash_host_pkg::S_RGAP;
        end
      end
      flash_host_pkg::S_RGAP:
      begin
        if (s_reg.op == flash_host_pkg::OP_ADD_BLK)
        begin
          // window closed: a late block would be taken as a stray command
          if (s_reg.rdata[flash_host_pkg::BIT_WINDOW])
          begin
            s_next.refused = 1'b1;
            finish = 1'b1;
          end
          else
            go_wr = 1'b1;
        end
        else if (!is_poll_op(s_reg.op))
          finish = 1'b1;
        else if (!s_reg.second)
        begin
          s_next.prev = s_reg.rdata;
          s_next.second = 1'b1;
          go_rd = 1'b1;
        end
        else if (s_reg.rdata[flash_host_pkg::BIT_TOGGLE] == s_reg.prev[flash_host_pkg::BIT_TOGGLE])
        begin
          // fail only trusted once the toggle flag stands still
          s_next.fail = s_reg.rdata[flash_host_pkg::BIT_FAIL];
          if (s_reg.op != flash_host_pkg::OP_SUSPEND)
            s_next.mode_busy = 1'b0;
          finish = 1'b1;
        end
        else
        begin
          s_next.prev = s_reg.rdata;
          go_rd = 1'b1;
        end
      end
      flash_host_pkg::S_RECOV:
      begin
        s_next.cnt = s_reg.cnt - 10'd1;
        if (s_reg.cnt == 10'd0)
          finish = 1'b1;
      end
    endcase
    if (apb_wr && paddr == flash_host_pkg::OFS_CTRL && s_reg.st != flash_host_pkg::S_IDLE)
      s_next.refused = 1'b1;
    wword = write_word(s_next.op, wr_step, s_next.addr, s_next.wdata);
    if (go_wr)
    begin
      s_next.st = flash_host_pkg::S_WR;
      s_next.step = wr_step;
      s_next.cnt = flash_host_pkg::WR_LOW_CYC - 10'd1;
      s_next.pin_addr = wword[26:8];
      s_next.pin_dq = wword[7:0];
      s_next.pin_dq_oe = 1'b1;
      s_next.pin_ce_n = 1'b0;
      s_next.pin_we_n = 1'b0;
    end
    if (go_rd)
    begin
      s_next.st = flash_host_pkg::S_RD;
      s_next.cnt = flash_host_pkg::RD_WAIT_CYC - 10'd1;
      s_next.pin_addr = s_next.addr;
      s_next.pin_ce_n = 1'b0;
      s_next.pin_oe_n = 1'b0;
    end
    if (finish)
    begin
      s_next.st = flash_host_pkg::S_IDLE;
      s_next.done = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= flash_host_pkg::CTL_RESET;
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // APB read side and pins
  // ----------------------------------------------------------------
  logic mapped;
  always_comb
  begin
    prdata = 32'h00000000;
    mapped = 1'b1;
    unique case (paddr)
      flash_host_pkg::OFS_CTRL:   prdata = {28'h0000000, s_reg.op};
      flash_host_pkg::OFS_ADDR:   prdata = {13'h0000, s_reg.cfg_addr};
      flash_host_pkg::OFS_WDATA:  prdata = {24'h000000, s_reg.cfg_data};
      flash_host_pkg::OFS_STATUS: prdata = {26'h0000000, s_reg.mode_busy, s_reg.rb_s2,
                                            s_reg.refused, s_reg.fail, s_reg.done,
                                            s_reg.st != flash_host_pkg::S_IDLE};
      flash_host_pkg::OFS_RDATA:  prdata = {24'h000000, s_reg.rdata};
      default:                    mapped = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign flash_addr = s_reg.pin_addr;
  assign dq_out = s_reg.pin_dq;
  assign dq_oe = s_reg.pin_dq_oe;
  assign ce_n = s_reg.pin_ce_n;
  assign oe_n = s_reg.pin_oe_n;
  assign we_n = s_reg.pin_we_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [9:0] recov_seen;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      recov_seen <= 10'd0;
    else
      recov_seen <= (s_reg.st == flash_host_pkg::S_RECOV) ? recov_seen + 10'd1 : 10'd0;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_UNLOCK_FIRST: assert property ($fell(we_n) && s_reg.step == 3'd0 &&
      write_count(s_reg.op) > 3'd1 |-> flash_addr == 19'h05555 && dq_out == 8'hAA)
    else $error("first unlock cycle wrong");
  AST_UNLOCK_SECOND: assert property ($fell(we_n) && s_reg.step == 3'd1 |->
      flash_addr == 19'h02AAA && dq_out == 8'h55)
    else $error("second unlock cycle wrong");
  AST_RESET_CMD: assert property ($fell(we_n) && s_reg.op == flash_host_pkg::OP_RESET &&
      s_reg.step == 3'd2 |-> dq_out == 8'hF0)
    else $error("reset-read command byte wrong");
  AST_RECOV_WAIT: assert property (s_reg.st == flash_host_pkg::S_RECOV &&
      s_next.st != flash_host_pkg::S_RECOV |-> recov_seen == 10'd499)
    else $error("recovery wait cut short");
  AST_ADD_IN_WINDOW: assert property ($fell(we_n) && s_reg.op == flash_host_pkg::OP_ADD_BLK
      |-> s_reg.rdata[flash_host_pkg::BIT_WINDOW] == 1'b0)
    else $error("block appended after window closed");
  AST_DONE_TOGGLE_STILL: assert property ($rose(s_reg.done) && s_reg.op == flash_host_pkg::OP_POLL
      |-> s_reg.rdata[6] == s_reg.prev[6])
    else $error("poll finished while toggling");
  AST_FAIL_AFTER_STOP: assert property ($rose(s_reg.fail) |-> $rose(s_reg.done) &&
      s_reg.rdata[6] == s_reg.prev[6])
    else $error("fail reported before completion");
  AST_WE_PULSE: assert property ($fell(we_n) |-> !we_n [*3] ##1 (we_n && dq_oe))
    else $error("write strobe width wrong");
  AST_NO_CLASH: assert property (!(oe_n == 1'b0 && (we_n == 1'b0 || dq_oe)))
    else $error("read and write overlap");

  COV_PROGRAM: cover property ($rose(s_reg.done) && s_reg.op == flash_host_pkg::OP_PROGRAM);
  COV_RECOV: cover property (s_reg.st == flash_host_pkg::S_RECOV ##1 s_reg.done);
  COV_ADD_REFUSED: cover property ($rose(s_reg.refused) && s_reg.op == flash_host_pkg::OP_ADD_BLK);
  COV_FAIL: cover property ($rose(s_reg.fail));
endmodule : flash_host_ctl
`default_nettype wire

// ==== tb/flash_dev_model.sv ====
// behavioural byte-wide flash that answers the controller's pins
`default_nettype none
module flash_dev_model #(
  parameter logic [7:0] MAKER_ID   = 8'h3C, // arbitrary value
  parameter logic [7:0] DEVICE_ID  = 8'hC3, // arbitrary value
  parameter logic [5:0] PROT_BLOCK = 6'h02,
  parameter int         BUSY_READS = 4
) (
  input  wire logic [18:0] flash_addr,
  input  wire logic [7:0]  dq_out,
  input  wire logic        dq_oe,
  output logic      [7:0]  dq_in,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  output logic             ready_busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  typedef enum logic [2:0] {M_ARRAY, M_SIG, M_PROG, M_ERASE, M_SUSP, M_DONE} mode_t;
  mode_t       mode_reg = M_ARRAY;
  logic [7:0]  mem [int];
  logic [63:0] blocks_reg = '0;
  logic [2:0]  step_reg = '0;
  logic [18:0] paddr_reg = '0;
  logic [7:0]  pdata_reg = '0, rd_reg = '0, last_reg = '0;
  logic        chip_reg = '0, fail_reg = '0, tog6_reg = '0, tog2_reg = '0;
  int          reads_reg = 0;
  realtime     t_blk = 0;

  function automatic logic [7:0] rdmem(input logic [18:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
  endfunction : rdmem
  // window closes 60 us after the last block command
  function automatic logic win_open();
    return mode_reg == M_ERASE && !chip_reg && ($realtime - t_blk) < 60000.0;
  endfunction : win_open
  function automatic logic [7:0] rd_val();
    logic inblk;
    inblk = chip_reg || blocks_reg[flash_addr[18:13]];
    case (mode_reg)
      M_SIG:   return flash_addr[1] ? {7'h00, flash_addr[18:13] == PROT_BLOCK}
                                    : (flash_addr[0] ? DEVICE_ID : MAKER_ID);
      M_PROG:  return {~pdata_reg[7], tog6_reg, fail_reg, 2'h0, 1'h1, 2'h0};
      M_ERASE: return {1'h0, tog6_reg, fail_reg, 1'h0, ~win_open(),
                       inblk ? tog2_reg : 1'h1, 2'h0};
      M_SUSP:  return inblk ? {5'h19, tog2_reg, 2'h0} : rdmem(flash_addr);
      M_DONE:  return {1'h1, tog6_reg, fail_reg, 2'h1, (fail_reg && inblk) ? tog2_reg : 1'h1,
                       2'h0};
      default: return rdmem(flash_addr);
    endcase
  endfunction : rd_val

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // a released bus shows the inverse of the last byte, never a stale copy
  assign dq_in = dq_oe ? dq_out : ((!ce_n && !oe_n) ? rd_reg : ~last_reg);
  assign ready_busy_out = !((mode_reg == M_PROG && !fail_reg) || mode_reg == M_ERASE);

  always @(negedge oe_n)
  begin
    #1;
    rd_reg = rd_val();
  end

  always @(posedge oe_n)
  begin
    last_reg = rd_reg;
    tog2_reg = ~tog2_reg;
    if (!ready_busy_out)
    begin
      tog6_reg = ~tog6_reg;
      if (!win_open())
        reads_reg++;
      if (reads_reg >= BUSY_READS)
        complete();
    end
  end

  task automatic complete();
    int keys[$];
    if (mode_reg == M_PROG)
      mem[int'(paddr_reg)] = pdata_reg & rdmem(paddr_reg);
    foreach (mem[k])
      if (mode_reg == M_ERASE && (chip_reg || blocks_reg[k[18:13]]))
        keys.push_back(k);
    foreach (keys[i])
      mem.delete(keys[i]);
    mode_reg = (mode_reg == M_PROG) ? M_ARRAY : M_DONE;
  endtask : complete

  // ----------------------------------------------------------------
  // command decoder
  // ----------------------------------------------------------------
  always @(posedge we_n)
  begin
    logic [14:0] a;
    logic [7:0]  d;
    a = flash_addr[14:0];
    d = dq_out;
    if (mode_reg == M_ERASE)
    begin
      if (d == 8'hB0 && !win_open())
        mode_reg = M_SUSP;
      else if (d == 8'h30 && win_open())
      begin
        blocks_reg[flash_addr[18:13]] = 1'h1;
        t_blk = $realtime;
      end
    end
    else if (mode_reg == M_SUSP)
      mode_reg = (d == 8'h30) ? M_ERASE : M_SUSP;
    else if (mode_reg == M_PROG && !fail_reg)
      step_reg = '0;
    else if (step_reg == 3'h6)
    begin
      {step_reg, pdata_reg, paddr_reg, reads_reg} = {3'h0, d, flash_addr, 32'h0};
      fail_reg = |(d & ~rdmem(flash_addr));
      mode_reg = M_PROG;
    end
    else if (d == 8'hF0 && (step_reg == 3'h0 || step_reg == 3'h2))
      {mode_reg, fail_reg, step_reg} = {M_ARRAY, 1'h0, 3'h0};
    else if ((step_reg == 3'h0 || step_reg == 3'h3) && a == 15'h5555 && d == 8'hAA)
      step_reg++;
    else if ((step_reg == 3'h1 || step_reg == 3'h4) && a == 15'h2AAA && d == 8'h55)
      step_reg++;
    else if (step_reg == 3'h2 && a == 15'h5555 && d == 8'h90)
      {mode_reg, step_reg} = {M_SIG, 3'h0};
    else if (step_reg == 3'h2 && a == 15'h5555 && (d == 8'hA0 || d == 8'h80))
      step_reg = (d == 8'hA0) ? 3'h6 : 3'h3;
    else if (step_reg == 3'h5 && (d == 8'h10 || d == 8'h30))
    begin
      chip_reg = (d == 8'h10);
      blocks_reg = 64'h0 | ((d == 8'h30) << flash_addr[18:13]);
      {mode_reg, reads_reg, fail_reg, step_reg} = {M_ERASE, 32'h0, 1'h0, 3'h0};
      t_blk = $realtime;
    end
    else
      {mode_reg, step_reg} = {M_ARRAY, 3'h0};
  end
endmodule : flash_dev_model
`default_nettype wire

// ==== tb/flash_host_ctl_tb_top.sv ====
// self-checking bench: APB master, flash model and operation table
`default_nettype none
module flash_host_ctl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
  localparam logic [7:0] DEVID = 8'hC3; // arbitrary value
  typedef struct packed {
    logic [3:0] op; logic [18:0] addr; logic [7:0] wd; logic [5:0] st; logic chk; logic [7:0] rd;
  } row_t;
  localparam row_t ROWS [13] = '{
    '{flash_host_pkg::OP_READ,    19'h00010, 8'h00, 6'h12, 1'h1, 8'hFF},
    '{flash_host_pkg::OP_PROGRAM, 19'h00010, 8'h5A, 6'h12, 1'h0, 8'h00},
    '{flash_host_pkg::OP_READ,    19'h00010, 8'h00, 6'h12, 1'h1, 8'h5A},
    '{flash_host_pkg::OP_PROGRAM, 19'h00010, 8'hFF, 6'h16, 1'h0, 8'h00},
    '{flash_host_pkg::OP_RESET,   19'h00000, 8'h00, 6'h12, 1'h0, 8'h00},
    '{flash_host_pkg::OP_SIG,     19'h00000, 8'h00, 6'h12, 1'h1, MAKER},
    '{flash_host_pkg::OP_SIG,     19'h00001, 8'h00, 6'h12, 1'h1, DEVID},
    '{flash_host_pkg::OP_SIG,     19'h04002, 8'h00, 6'h12, 1'h1, 8'h01},
    '{flash_host_pkg::OP_SIG,     19'h08002, 8'h00, 6'h12, 1'h1, 8'h00},
    '{flash_host_pkg::OP_RESET,   19'h00000, 8'h00, 6'h12, 1'h0, 8'h00},
    '{flash_host_pkg::OP_CHIP,    19'h00010, 8'h00, 6'h12, 1'h0, 8'h00},
    '{flash_host_pkg::OP_RESET,   19'h00000, 8'h00, 6'h12, 1'h0, 8'h00},
    '{flash_host_pkg::OP_READ,    19'h00010, 8'h00, 6'h12, 1'h1, 8'hFF}};
  logic        pclk = '0, presetn = '1, psel = '0, penable = '0, pwrite = '0, er;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, dq_oe, ce_n, oe_n, we_n, ready_busy_out;
  logic [18:0] flash_addr;
  logic [7:0]  dq_out, dq_in;
  int          fails = 0, samples_checked = 0;

  always #10 pclk = ~pclk;

  flash_host_ctl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .ready_busy_out(ready_busy_out));
  flash_dev_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVID)) u_flash (.flash_addr(flash_addr),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .ready_busy_out(ready_busy_out));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_of_test(input int extra);
    fails += extra;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one idle edge after each transfer keeps psel from being driven twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    for (n = 0; pready !== 1'h1 && n < 50; n++)
      @(posedge pclk);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    @(posedge pclk);
    if (n >= 50)
      end_of_test(1);
  endtask : apb
  task automatic wait_idle();
    int n;
    for (n = 0; n < 8000; n++)
    begin
      apb(1'h0, flash_host_pkg::OFS_STATUS, 32'h0);
      if (rd[0] === 1'h0)
        break;
    end
    if (n >= 8000)
      end_of_test(1);
  endtask : wait_idle
  task automatic run(input logic [3:0] op, input logic [18:0] a, input logic [7:0] d);
    apb(1'h1, flash_host_pkg::OFS_ADDR, {13'h0, a});
    apb(1'h1, flash_host_pkg::OFS_WDATA, {24'h0, d});
    apb(1'h1, flash_host_pkg::OFS_CTRL, {28'h0, op});
    wait_idle();
  endtask : run

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, flash_host_pkg::OFS_STATUS, 32'h0);
    check("status after reset", rd, 32'h10);
    foreach (ROWS[i])
    begin
      run(ROWS[i].op, ROWS[i].addr, ROWS[i].wd);
      check("row status", rd, {26'h0, ROWS[i].st});
      apb(1'h0, flash_host_pkg::OFS_RDATA, 32'h0);
      check("row rdata", ROWS[i].chk ? rd : {31'h0, er}, {24'h0, ROWS[i].rd});
      $display("row %0d finished", i);
    end
    run(flash_host_pkg::OP_BLK_ERA, 19'h04000, 8'h00);
    check("erase launch", rd, 32'h22);
    run(flash_host_pkg::OP_ADD_BLK, 19'h08000, 8'h00);
    check("append in window", rd, 32'h22);
    apb(1'h1, flash_host_pkg::OFS_CTRL, {28'h0, flash_host_pkg::OP_POLL});
    apb(1'h1, flash_host_pkg::OFS_CTRL, {28'h0, flash_host_pkg::OP_READ});
    wait_idle();
    check("poll with refused launch", rd, 32'h1A);
    $display("append test finished");
    run(flash_host_pkg::OP_BLK_ERA, 19'h04000, 8'h00);
    repeat (3500) @(posedge pclk);
    run(flash_host_pkg::OP_ADD_BLK, 19'h08000, 8'h00);
    check("append after window", rd, 32'h2A);
    run(flash_host_pkg::OP_SUSPEND, 19'h04000, 8'h00);
    check("suspend", rd, 32'h32);
    run(flash_host_pkg::OP_READ, 19'h00010, 8'h00);
    apb(1'h0, flash_host_pkg::OFS_RDATA, 32'h0);
    check("read outside erase", rd, 32'hFF);
    run(flash_host_pkg::OP_READ, 19'h04000, 8'h00);
    apb(1'h0, flash_host_pkg::OFS_RDATA, 32'h0);
    check("read inside erase", rd & 32'hFB, 32'hC8);
    run(flash_host_pkg::OP_RESUME, 19'h04000, 8'h00);
    check("resume", rd, 32'h22);
    run(flash_host_pkg::OP_POLL, 19'h04000, 8'h00);
    check("erase complete", rd, 32'h12);
    $display("suspend test finished");
    run(flash_host_pkg::OP_BLK_ERA, 19'h04000, 8'h00);
    run(flash_host_pkg::OP_RESET, 19'h00000, 8'h00);
    check("reset after erase", rd, 32'h02);
    $display("recovery test finished");
    apb(1'h1, 8'h14, 32'h0000_00A5);
    check("unmapped write error", {31'h0, er}, 32'h1);
    apb(1'h0, 8'h14, 32'h0);
    check("unmapped read", {rd[30:0], er}, 32'h1);
    $display("unmapped test finished");
    end_of_test(0);
  end
endmodule : flash_host_ctl_tb_top
`default_nettype wire
